// [isc_pkg.sv]
// Purpose: shared constants and carriers for the instruction-side
//          on-chip memory controller
// Assumes: one clock, core_clk, at 125 MHz; synchronous active-high reset
// Notes:   processor addresses are big-endian numbered; bit 0 is the msb
// Notes on behaviour
// - at reset the 8-bit config attribute is loaded into controller_config.
// - at reset the 8-bit region attribute is loaded into region_select.
// - fabric ties the attributes and they reload on every reset.
// - write_addr_initial and fill_data change only by software writes and by reset to zero.
// - region_select and controller_config stay readable and writable.
// - eight-bit variant takes register address bits 9..2 from the tie.
// - eight-bit variant low bits 0..3 pick init, fill, region, config.
// - six-bit variant takes bits 9..4 from the tie, registers at 0..3.
// - mem_read_enable is high only for valid in-region fetch cycles.
// - fetch_read_addr carries processor address bits 8..28.
// - address bits 0..7 must match region_select for a fetch to go on.
// - debug_write_addr starts from the write_addr_initial value.
// - debug_write_data starts from the fill_data value.
package isc_pkg;

   // =========================================================
   // device control bus layout
   localparam int unsigned ISC_DCR_AW = 10;
   localparam int unsigned ISC_DW = 32;
   localparam logic [1:0] ISC_IDX_WR_ADDR_INIT = 2'h0;
   localparam logic [1:0] ISC_IDX_FILL_DATA = 2'h1;
   localparam logic [1:0] ISC_IDX_REGION = 2'h2;
   localparam logic [1:0] ISC_IDX_CONFIG = 2'h3;
   localparam logic [1:0] ISC_TIE6_NIBBLE_HI = 2'h0;

   // =========================================================
   // field positions (little-endian indices of a 32-bit address)
   localparam int unsigned ISC_ATTR_W = 8;
   localparam int unsigned ISC_FADDR_W = 21;
   localparam int unsigned ISC_REGION_LSB = 24;
   localparam int unsigned ISC_FADDR_LSB = 3;

   // =========================================================
   // reset values and steps
   localparam logic [31:0] ISC_WR_ADDR_INIT_RST = 32'h0000_0000;
   localparam logic [31:0] ISC_FILL_DATA_RST = 32'h0000_0000;
   localparam logic [20:0] ISC_WADDR_STEP = 21'h00_0001;

   // =========================================================
   // carriers
   typedef struct packed
   {
      logic req;
      logic wr;
      logic [ISC_DCR_AW-1:0] addr;
      logic [ISC_DW-1:0] wdata;
   } isc_dcr_req_t;

   typedef struct packed
   {
      logic ack;
      logic [ISC_DW-1:0] rdata;
   } isc_dcr_rsp_t;

   typedef struct packed
   {
      logic valid;
      logic [31:0] addr;
   } isc_fetch_t;

   typedef enum logic {ISC_BASE_SIX, ISC_BASE_EIGHT} isc_base_mode_t;

endpackage

// [isc_instr_mem_ctrl.sv]
// Purpose: instruction-side on-chip memory controller: control registers
//          on the device control bus, region decode and fetch read port
// Assumes: fetch requests and bus requests come from logic on core_clk;
//          attribute and base ties come from fabric and are synchronised
// Notes:   read data return path and bank write enables live elsewhere
`timescale 1ns/1ps

module isc_instr_mem_ctrl
   import isc_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [ISC_ATTR_W-1:0] config_attr_in,
   input wire logic [ISC_ATTR_W-1:0] region_attr_in,
   input wire logic [7:0] reg_base_tie8,
   input wire logic [5:0] reg_base_tie6,
   input wire logic base_mode_eight,
   input wire isc_dcr_req_t dcr_req,
   output isc_dcr_rsp_t dcr_rsp,
   input wire isc_fetch_t fetch_in,
   output logic mem_read_enable,
   output logic [ISC_FADDR_W-1:0] fetch_read_addr,
   output logic [ISC_FADDR_W-1:0] debug_write_addr,
   output logic [ISC_DW-1:0] debug_write_data,
   output logic debug_write_strobe,
   output logic [ISC_ATTR_W-1:0] config_out
);

   // =========================================================
   // tie synchronisers
   logic [ISC_ATTR_W-1:0] cfg_attr_s1_r;
   logic [ISC_ATTR_W-1:0] cfg_attr_s2_r;
   logic [ISC_ATTR_W-1:0] reg_attr_s1_r;
   logic [ISC_ATTR_W-1:0] reg_attr_s2_r;
   logic [7:0] tie8_s1_r;
   logic [7:0] tie8_s2_r;
   logic [5:0] tie6_s1_r;
   logic [5:0] tie6_s2_r;
   logic mode_s1_r;
   logic mode_s2_r;
   isc_base_mode_t base_mode;

   // =========================================================
   // registers and decode
   logic [ISC_DW-1:0] wr_addr_init_r;
   logic [ISC_DW-1:0] fill_data_r;
   logic [ISC_ATTR_W-1:0] region_select_r;
   logic [ISC_ATTR_W-1:0] ctrl_config_r;
   logic dcr_hit;
   logic [1:0] dcr_idx;
   logic dcr_wr_hit;
   logic dcr_rd_hit;
   logic dcr_ack_r;
   logic [ISC_DW-1:0] dcr_rdata_r;
   logic [ISC_DW-1:0] rd_mux;

   // =========================================================
   // fetch and debug path state
   logic fetch_hit;
   logic mem_rd_en_r;
   logic [ISC_FADDR_W-1:0] fetch_addr_r;
   logic [ISC_FADDR_W-1:0] dbg_addr_r;
   logic [ISC_DW-1:0] dbg_data_r;
   logic dbg_strobe_r;

   // =========================================================
   // functions

   // address decode shared by the read and write paths; returns
   // {hit, index}.  the two low bits are fixed inside the block
   function automatic logic [2:0] isc_decode
   (
      input isc_base_mode_t mode,
      input logic [ISC_DCR_AW-1:0] addr,
      input logic [7:0] tie8,
      input logic [5:0] tie6
   );
      logic hit;
      hit = 1'b0;
      if (mode == ISC_BASE_EIGHT)
      begin
         hit = (addr[9:2] == tie8);
      end
      else
      begin
         // the six-bit base is shared with other sub-blocks, so the
         // controller owns only the first four words of its nibble
         hit = (addr[9:4] == tie6) &&
               (addr[3:2] == ISC_TIE6_NIBBLE_HI);
      end
      isc_decode = {hit, addr[1:0]};
   endfunction

   // region compare: processor address bits 0..7 against region_select
   function automatic logic isc_region_match
   (
      input logic [31:0] paddr,
      input logic [ISC_ATTR_W-1:0] region
   );
      isc_region_match =
         (paddr[ISC_REGION_LSB +: ISC_ATTR_W] == region);
   endfunction

   // =========================================================
   // synchronisers: ties are static, but they arrive from fabric
   // outside this clock, so two stages keep metastability out
   always_ff @(posedge core_clk)
   begin
      cfg_attr_s1_r <= config_attr_in;
      cfg_attr_s2_r <= cfg_attr_s1_r;
      reg_attr_s1_r <= region_attr_in;
      reg_attr_s2_r <= reg_attr_s1_r;
      tie8_s1_r <= reg_base_tie8;
      tie8_s2_r <= tie8_s1_r;
      tie6_s1_r <= reg_base_tie6;
      tie6_s2_r <= tie6_s1_r;
      mode_s1_r <= base_mode_eight;
      mode_s2_r <= mode_s1_r;
   end

   assign base_mode = mode_s2_r ? ISC_BASE_EIGHT : ISC_BASE_SIX;

   // =========================================================
   // bus decode
   always_comb
   begin
      logic [2:0] dec;
      dec = isc_decode(base_mode, dcr_req.addr, tie8_s2_r, tie6_s2_r);
      dcr_hit = dec[2];
      dcr_idx = dec[1:0];
   end

   assign dcr_wr_hit = dcr_req.req && dcr_req.wr && dcr_hit;
   assign dcr_rd_hit = dcr_req.req && !dcr_req.wr && dcr_hit;

   // =========================================================
   // write_addr_initial: software only, never from an attribute
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wr_addr_init_r <= ISC_WR_ADDR_INIT_RST;
      end
      else if (dcr_wr_hit && dcr_idx == ISC_IDX_WR_ADDR_INIT)
      begin
         wr_addr_init_r <= dcr_req.wdata;
      end
   end

   // fill_data: software only, never from an attribute
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         fill_data_r <= ISC_FILL_DATA_RST;
      end
      else if (dcr_wr_hit && dcr_idx == ISC_IDX_FILL_DATA)
      begin
         fill_data_r <= dcr_req.wdata;
      end
   end

   // region_select: reloaded from the tie during every reset cycle,
   // so reset must be long enough for the synchroniser to fill
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         region_select_r <= reg_attr_s2_r;
      end
      else if (dcr_wr_hit && dcr_idx == ISC_IDX_REGION)
      begin
         region_select_r <= dcr_req.wdata[ISC_ATTR_W-1:0];
      end
   end

   // controller_config: same reload scheme as region_select
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         ctrl_config_r <= cfg_attr_s2_r;
      end
      else if (dcr_wr_hit && dcr_idx == ISC_IDX_CONFIG)
      begin
         ctrl_config_r <= dcr_req.wdata[ISC_ATTR_W-1:0];
      end
   end

   // =========================================================
   // read mux: eight-bit registers sit in the low byte
   always_comb
   begin
      rd_mux = '0;
      case (dcr_idx)
         ISC_IDX_WR_ADDR_INIT: rd_mux = wr_addr_init_r;
         ISC_IDX_FILL_DATA: rd_mux = fill_data_r;
         ISC_IDX_REGION: rd_mux[ISC_ATTR_W-1:0] = region_select_r;
         ISC_IDX_CONFIG: rd_mux[ISC_ATTR_W-1:0] = ctrl_config_r;
         default: rd_mux = '0;
      endcase
   end

   // bus answer one cycle after the request; an unmapped address gets
   // no ack, leaving the answer to whichever block owns it
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dcr_ack_r <= 1'b0;
         dcr_rdata_r <= '0;
      end
      else
      begin
         dcr_ack_r <= dcr_wr_hit || dcr_rd_hit;
         dcr_rdata_r <= dcr_rd_hit ? rd_mux : '0;
      end
   end

   assign dcr_rsp.ack = dcr_ack_r;
   assign dcr_rsp.rdata = dcr_rdata_r;

   // =========================================================
   // fetch path
   assign fetch_hit = fetch_in.valid &&
      isc_region_match(fetch_in.addr, region_select_r);

   // enable follows hits only; the memory may tie its own enable high,
   // so the address is kept stable on misses to avoid spurious reads
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         mem_rd_en_r <= 1'b0;
      end
      else
      begin
         mem_rd_en_r <= fetch_hit;
      end
   end

   // read address: processor bits 8..28 pick one 64-bit doubleword
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         fetch_addr_r <= '0;
      end
      else if (fetch_hit)
      begin
         fetch_addr_r <=
            fetch_in.addr[ISC_FADDR_LSB +: ISC_FADDR_W];
      end
   end

   // =========================================================
   // debug write path: the pointer reloads from write_addr_initial,
   // each fill write pulses the strobe, and the pointer then steps
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dbg_addr_r <= ISC_WR_ADDR_INIT_RST[ISC_FADDR_W-1:0];
      end
      else if (dcr_wr_hit && dcr_idx == ISC_IDX_WR_ADDR_INIT)
      begin
         dbg_addr_r <= dcr_req.wdata[ISC_FADDR_W-1:0];
      end
      else if (dbg_strobe_r)
      begin
         dbg_addr_r <= dbg_addr_r + ISC_WADDR_STEP;
      end
   end

   // write data mirrors fill_data; strobe marks the single write cycle
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dbg_data_r <= ISC_FILL_DATA_RST;
         dbg_strobe_r <= 1'b0;
      end
      else
      begin
         dbg_strobe_r <= dcr_wr_hit && dcr_idx == ISC_IDX_FILL_DATA;
         if (dcr_wr_hit && dcr_idx == ISC_IDX_FILL_DATA)
         begin
            dbg_data_r <= dcr_req.wdata;
         end
      end
   end

   // =========================================================
   // outputs
   assign mem_read_enable = mem_rd_en_r;
   assign fetch_read_addr = fetch_addr_r;
   assign debug_write_addr = dbg_addr_r;
   assign debug_write_data = dbg_data_r;
   assign debug_write_strobe = dbg_strobe_r;
   assign config_out = ctrl_config_r;

endmodule

// [isc_mem_ctrl_assertions.sv]
// Purpose: port-level checks of the instruction-side memory controller
// Assumes: ties and base mode stay put around bus traffic
// Notes:   region is mirrored here because it is not visible at a port
`timescale 1ns/1ps

module isc_mem_ctrl_assertions
   import isc_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [ISC_ATTR_W-1:0] config_attr_in,
   input wire logic [ISC_ATTR_W-1:0] region_attr_in,
   input wire logic [7:0] reg_base_tie8,
   input wire logic [5:0] reg_base_tie6,
   input wire logic base_mode_eight,
   input wire isc_dcr_req_t dcr_req,
   input wire isc_dcr_rsp_t dcr_rsp,
   input wire isc_fetch_t fetch_in,
   input wire logic mem_read_enable,
   input wire logic [ISC_FADDR_W-1:0] fetch_read_addr,
   input wire logic [ISC_FADDR_W-1:0] debug_write_addr,
   input wire logic [ISC_DW-1:0] debug_write_data,
   input wire logic debug_write_strobe,
   input wire logic [ISC_ATTR_W-1:0] config_out
);
   logic [7:0] region_r;
   logic hit, wr_hit, init_wr, fill_wr, fhit;

   // =========================================================
   // decode mirror
   assign hit = dcr_req.req && (base_mode_eight ?
      dcr_req.addr[9:2] == reg_base_tie8 :
      dcr_req.addr[9:2] == {reg_base_tie6, ISC_TIE6_NIBBLE_HI});
   assign wr_hit = hit && dcr_req.wr;
   assign init_wr = wr_hit && dcr_req.addr[1:0] == ISC_IDX_WR_ADDR_INIT;
   assign fill_wr = wr_hit && dcr_req.addr[1:0] == ISC_IDX_FILL_DATA;
   assign fhit = fetch_in.valid && fetch_in.addr[31:24] == region_r;

   // region mirror; reloads on each reset cycle as the block does
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         region_r <= region_attr_in;
      else if (wr_hit && dcr_req.addr[1:0] == ISC_IDX_REGION)
         region_r <= dcr_req.wdata[7:0];
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_fill;
      fill_wr;
   endsequence
   sequence s_step;
      s_fill ##1 !init_wr;
   endsequence

   // =========================================================
   // checks
   chk_ack_mapped: assert property (hit |=> dcr_rsp.ack)
      else $error("mapped access not acknowledged");
   chk_no_ack: assert property (!hit |=> !dcr_rsp.ack)
      else $error("unmapped access acknowledged");
   chk_rdata_idle: assert property (!dcr_rsp.ack |-> dcr_rsp.rdata == '0)
      else $error("read data not zero outside ack");
   chk_region_rd: assert property (hit && !dcr_req.wr &&
      dcr_req.addr[1:0] == ISC_IDX_REGION |=>
      dcr_rsp.rdata == {24'h0, $past(region_r)})
      else $error("region read back wrong");
   chk_cfg_reset: assert property ($fell(sys_rst) |->
      config_out == config_attr_in)
      else $error("config not loaded from attribute");
   chk_cfg_write: assert property (wr_hit &&
      dcr_req.addr[1:0] == ISC_IDX_CONFIG |=>
      config_out == $past(dcr_req.wdata[7:0]))
      else $error("config write lost");
   chk_fetch_hit: assert property (fhit |=> mem_read_enable &&
      fetch_read_addr == $past(fetch_in.addr[23:3]))
      else $error("in-region fetch not issued");
   chk_fetch_miss: assert property (!fhit |=>
      !mem_read_enable && $stable(fetch_read_addr))
      else $error("enable or address moved without a hit");
   chk_fill_strobe: assert property (s_fill |=>
      debug_write_strobe && debug_write_data == $past(dcr_req.wdata))
      else $error("fill write not presented");
   chk_init_load: assert property (init_wr |=>
      debug_write_addr == $past(dcr_req.wdata[20:0]))
      else $error("pointer not loaded from init write");
   chk_ptr_step: assert property (s_step |=>
      debug_write_addr == $past(debug_write_addr) + ISC_WADDR_STEP)
      else $error("pointer did not step after fill");
endmodule

bind isc_instr_mem_ctrl isc_mem_ctrl_assertions u_isc_mem_ctrl_assertions (
   .core_clk, .sys_rst, .config_attr_in, .region_attr_in, .reg_base_tie8,
   .reg_base_tie6, .base_mode_eight, .dcr_req, .dcr_rsp, .fetch_in,
   .mem_read_enable, .fetch_read_addr, .debug_write_addr,
   .debug_write_data, .debug_write_strobe, .config_out);

// [isc_fab_mem.sv]
// Purpose: behavioural fabric block memory on the fetch read port
// Assumes: clocked 1:1 with the controller
// Notes:   each doubleword holds its own address twice
`timescale 1ns/1ps

module isc_fab_mem
   import isc_pkg::*;
(
   input wire logic core_clk,
   input wire logic mem_en,
   input wire logic [ISC_FADDR_W-1:0] rd_addr,
   output logic [63:0] rd_data
);
   // reads only while enabled, so a missing enable leaves stale data
   always_ff @(posedge core_clk)
   begin
      if (mem_en)
         rd_data <= {11'h000, rd_addr, 11'h000, rd_addr};
   end
endmodule

// [isc_instr_mem_ctrl_tb_top.sv]
// Purpose: self-checking bench of the instruction-side memory controller
// Assumes: eight-bit base 0x0B, six-bit base 0x01
// Notes:   memory shares core_clk, ratio 1:1
`timescale 1ns/1ps

module isc_instr_mem_ctrl_tb_top
   import isc_pkg::*;
;
   typedef struct packed
   {
      logic wr;
      logic [9:0] addr;
      logic [31:0] wdata;
      logic ack;
      logic [31:0] rdata;
   } isc_row_t;

   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] config_attr_in = 8'h3C;
   logic [7:0] region_attr_in = 8'h40;
   logic [7:0] reg_base_tie8 = 8'h0B;
   logic [5:0] reg_base_tie6 = 6'h01;
   logic base_mode_eight = 1'b1;
   isc_dcr_req_t dcr_req = '0;
   isc_dcr_rsp_t dcr_rsp;
   isc_fetch_t fetch_in = '0;
   logic mem_read_enable, debug_write_strobe;
   logic [20:0] fetch_read_addr, debug_write_addr;
   logic [31:0] debug_write_data;
   logic [7:0] config_out;
   logic [63:0] rd_data;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   isc_row_t rows [10] = '{
      '{1'b0, 10'h02E, 32'h0, 1'b1, 32'h40},
      '{1'b0, 10'h02F, 32'h0, 1'b1, 32'h3C},
      '{1'b0, 10'h02C, 32'h0, 1'b1, 32'h0},
      '{1'b1, 10'h02E, 32'h12, 1'b1, 32'h0},
      '{1'b0, 10'h02E, 32'h0, 1'b1, 32'h12},
      '{1'b1, 10'h02F, 32'hA5, 1'b1, 32'h0},
      '{1'b0, 10'h02F, 32'h0, 1'b1, 32'hA5},
      '{1'b0, 10'h030, 32'h0, 1'b0, 32'h0},
      '{1'b1, 10'h02C, 32'h1_0005, 1'b1, 32'h0},
      '{1'b0, 10'h02C, 32'h0, 1'b1, 32'h1_0005}};

   always #4 core_clk = ~core_clk;

   isc_instr_mem_ctrl u_isc_instr_mem_ctrl (.core_clk, .sys_rst,
      .config_attr_in, .region_attr_in, .reg_base_tie8, .reg_base_tie6,
      .base_mode_eight, .dcr_req, .dcr_rsp, .fetch_in, .mem_read_enable,
      .fetch_read_addr, .debug_write_addr, .debug_write_data,
      .debug_write_strobe, .config_out);
   isc_fab_mem u_isc_fab_mem (.core_clk, .mem_en(mem_read_enable),
      .rd_addr(fetch_read_addr), .rd_data);

   // =========================================================
   // helpers
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         n_fail++;
      end
   endtask

   // one request pulse; ack and data are looked at one edge later
   task automatic acc(input logic wr, input logic [9:0] a,
      input logic [31:0] d, input logic ea, input logic [31:0] ed);
      @(posedge core_clk);
      dcr_req <= '{1'b1, wr, a, d};
      @(posedge core_clk);
      dcr_req.req <= 1'b0;
      #1;
      chk("ack", {31'h0, ea}, {31'h0, dcr_rsp.ack});
      chk("rdata", ed, dcr_rsp.rdata);
   endtask

   // the first edge already sees reset high at start-up, so four more
   // edges give five reset cycles, two more than the three the ties need to reload
   task automatic do_reset();
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
   endtask

   task automatic end_of_test();
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, far above the roughly 52 cycles the run needs
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         n_fail++;
         end_of_test();
      end
   end

   // =========================================================
   // sequence
   initial
   begin
      do_reset();
      foreach (rows[i])
         acc(rows[i].wr, rows[i].addr, rows[i].wdata, rows[i].ack,
            rows[i].rdata);
      // hit then miss back to back: address must hold on the miss
      @(posedge core_clk);
      fetch_in <= '{1'b1, 32'h1234_5678};
      @(posedge core_clk);
      fetch_in <= '{1'b1, 32'h4034_5678};
      #1;
      chk("en hit", 32'h1, 32'(mem_read_enable));
      chk("raddr", 32'h6_8ACF, 32'(fetch_read_addr));
      @(posedge core_clk);
      fetch_in.valid <= 1'b0;
      #1;
      chk("en miss", 32'h0, 32'(mem_read_enable));
      chk("raddr hold", 32'h6_8ACF, 32'(fetch_read_addr));
      chk("mem word", 32'h6_8ACF, rd_data[31:0]);
      // two fills step the pointer twice from the init value
      acc(1'b1, 10'h02D, 32'hDEAD_BEEF, 1'b1, 32'h0);
      acc(1'b1, 10'h02D, 32'h0BAD_F00D, 1'b1, 32'h0);
      chk("strobe on", 32'h1, 32'(debug_write_strobe));
      @(posedge core_clk);
      #1;
      chk("wdata", 32'h0BAD_F00D, debug_write_data);
      chk("waddr", 32'h1_0007, 32'(debug_write_addr));
      chk("strobe off", 32'h0, 32'(debug_write_strobe));
      // six-bit base: offsets 0..3 only, old base now unmapped
      @(posedge core_clk);
      base_mode_eight <= 1'b0;
      repeat (3) @(posedge core_clk);
      acc(1'b0, 10'h012, 32'h0, 1'b1, 32'h12);
      acc(1'b0, 10'h02E, 32'h0, 1'b0, 32'h0);
      acc(1'b0, 10'h016, 32'h0, 1'b0, 32'h0);
      // a later reset reloads the attributes over software values
      do_reset();
      acc(1'b0, 10'h012, 32'h0, 1'b1, 32'h40);
      acc(1'b0, 10'h011, 32'h0, 1'b1, 32'h0);
      chk("cfg out", 32'h3C, 32'(config_out));
      end_of_test();
   end
endmodule
